// *** src/pgm_defines.svh ***
`ifndef PGM_DEFINES_SVH
`define PGM_DEFINES_SVH
// Overview of operation
// - G bits 7,6: I/O, or LCD com 3,2
// - G bits 5,4: I/O, or LCD com 1,0
// - H3: timer clock5, analog 13, segment 41
// - H2: timer clock4, analog 12, segment 42
// - H1: capture5, timer5 output, segment 19
// - H0: capture4, timer4 output, segment 20
// - H7: capture7, timer7 output, segment 17
// - H6: capture6, timer6 output, segment 18
// - H5: timer clock7, analog 15, segment 39
// - H4: timer clock6, analog 14, segment 40
// - J3: I/O, LCD com 7, segment 3
// - J2..J0: I/O, com 6..4, segment 2..0
// - J7: I/O with timer clock4, segment 11
// - J6: I/O with timer clock5, segment 10
// - small part: J upper bits 3:0 read zero
// - J5,J4: I/O with clocks 6,7; segments 9,8
// - timer clocks 3..0 routed by bits 6..3
// - standard clocks 2..0 routed by bits 2..0

// register byte offsets on the bus
`define PGM_OFS_G_UPPER     8'h00
`define PGM_OFS_H_LOWER     8'h04
`define PGM_OFS_H_UPPER     8'h08
`define PGM_OFS_J_LOWER     8'h0C
`define PGM_OFS_J_UPPER     8'h10
`define PGM_OFS_CLK_ROUTE   8'h14

// reset values
`define PGM_RST_SEL         8'h00

// implemented bit masks
`define PGM_MASK_FULL       8'hFF
`define PGM_MASK_J_SMALL    8'hF0
`define PGM_MASK_CLK_ROUTE  8'h7F

// field codes
`define PGM_CODE_ALT2       2'h2
`define PGM_CODE_ALT3       2'h3

// route register field positions
`define PGM_PT_ROUTE_LSB    3
`define PGM_ST_ROUTE_LSB    0

// port H: pins that carry a timer pin at code 10 (others analog)
`define PGM_H_TIMER_PINS    8'hC3
// port H segment number per pin, pin 7 first
`define PGM_H_SEG_MAP \
  {6'h11, 6'h12, 6'h27, 6'h28, 6'h29, 6'h2A, 6'h13, 6'h14}
`endif

// *** src/pgm_pkg.sv ***
package pgm_pkg;
  // drive of eight pads: level and enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pgm_pad_bus_t;

  // timer-side signals gathered by the mux
  typedef struct packed {
    logic [7:0] ptClk;     // periodic timer clock inputs 7..0
    logic [2:0] stClk;     // standard timer clock inputs 2..0
    logic [7:4] ptCap;     // periodic timer capture inputs 7..4
  } pgm_timer_in_t;

  typedef enum logic [0:0] {
    PGM_SIZE_LARGE = 1'b0,
    PGM_SIZE_SMALL = 1'b1
  } pgm_size_t;
endpackage : pgm_pkg

// *** src/pgm_port_ghj_mux.sv ***
`timescale 1ns/1ps
`include "pgm_defines.svh"
module pgm_port_ghj_mux #(
  parameter pgm_pkg::pgm_size_t PART_SIZE = pgm_pkg::PGM_SIZE_LARGE
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  // wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // general I/O drive from the port logic
  input  wire pgm_pkg::pgm_pad_bus_t gpioG,
  input  wire pgm_pkg::pgm_pad_bus_t gpioH,
  input  wire pgm_pkg::pgm_pad_bus_t gpioJ,
  // pad levels
  input  wire logic [7:0]            padGIn,
  input  wire logic [7:0]            padHIn,
  input  wire logic [7:0]            padJIn,
  // peripheral drives
  input  wire logic [7:4]            ptOut,
  input  wire logic [7:0]            lcdComDrv,
  input  wire logic [42:0]           lcdSegDrv,
  // candidate pins for routed clocks, order 3..0 / 2..0
  input  wire logic [3:0]            ptClkPinA,
  input  wire logic [3:0]            ptClkPinB,
  input  wire logic [2:0]            stClkPinA,
  input  wire logic [2:0]            stClkPinB,
  // pad drive results
  output pgm_pkg::pgm_pad_bus_t      padG,
  output pgm_pkg::pgm_pad_bus_t      padH,
  output pgm_pkg::pgm_pad_bus_t      padJ,
  output logic      [15:12]          analogSel,
  output logic      [7:4]            ptClkFromJ,
  output pgm_pkg::pgm_timer_in_t     timerIn
);
  import pgm_pkg::*;

  localparam logic [7:0] J_UPPER_MASK = (PART_SIZE == PGM_SIZE_SMALL) ?
    `PGM_MASK_J_SMALL : `PGM_MASK_FULL;
  localparam logic [7:0]      H_TIMER = `PGM_H_TIMER_PINS;
  localparam logic [47:0]     H_SEG   = `PGM_H_SEG_MAP;

  logic [7:0]  gUpperSel_ff;
  logic [7:0]  hLowerSel_ff;
  logic [7:0]  hUpperSel_ff;
  logic [7:0]  jLowerSel_ff;
  logic [7:0]  jUpperSel_ff;
  logic [7:0]  clkRoute_ff;
  logic        ack_ff;
  logic [31:0] rdData_ff;
  logic        busReq;
  logic        wrEn;
  logic [7:0]  rdMux;
  logic        hitMap;

  pgm_pad_bus_t  nxt_padG;
  pgm_pad_bus_t  nxt_padH;
  pgm_pad_bus_t  nxt_padJ;
  logic [15:12]  nxt_analogSel;
  logic [7:4]    nxt_ptClkFromJ;
  pgm_timer_in_t nxt_timerIn;
  logic [15:0]   hSel;

  assign hSel = {hUpperSel_ff, hLowerSel_ff};

  // bus handshake: one wait state, ack drops the cycle after
  assign busReq = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wrEn   = busReq & wb_we_i & wb_sel_i[0];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= busReq;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdData_ff;

  // read decode; unmapped words read zero but still ack
  always_comb begin
    rdMux  = 8'h00;
    hitMap = 1'b1;
    unique case (wb_adr_i)
      `PGM_OFS_G_UPPER:   rdMux = gUpperSel_ff;
      `PGM_OFS_H_LOWER:   rdMux = hLowerSel_ff;
      `PGM_OFS_H_UPPER:   rdMux = hUpperSel_ff;
      `PGM_OFS_J_LOWER:   rdMux = jLowerSel_ff;
      `PGM_OFS_J_UPPER:   rdMux = jUpperSel_ff;
      `PGM_OFS_CLK_ROUTE: rdMux = clkRoute_ff;
      default:            hitMap = 1'b0;
    endcase
  end

  // read data captured with the ack, upper bits zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_ff <= 32'h0000_0000;
    end else if (busReq) begin
      rdData_ff <= hitMap ? {24'h00_0000, rdMux} : 32'h0000_0000;
    end
  end

  // select registers; only byte lane 0 carries data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gUpperSel_ff <= `PGM_RST_SEL;
      hLowerSel_ff <= `PGM_RST_SEL;
      hUpperSel_ff <= `PGM_RST_SEL;
      jLowerSel_ff <= `PGM_RST_SEL;
      jUpperSel_ff <= `PGM_RST_SEL;
      clkRoute_ff  <= `PGM_RST_SEL;
    end else if (wrEn) begin
      unique case (wb_adr_i)
        `PGM_OFS_G_UPPER: gUpperSel_ff <= wb_dat_i[7:0];
        `PGM_OFS_H_LOWER: hLowerSel_ff <= wb_dat_i[7:0];
        `PGM_OFS_H_UPPER: hUpperSel_ff <= wb_dat_i[7:0];
        `PGM_OFS_J_LOWER: jLowerSel_ff <= wb_dat_i[7:0];
        // unimplemented bits never store, so read as zero
        `PGM_OFS_J_UPPER:
          jUpperSel_ff <= wb_dat_i[7:0] & J_UPPER_MASK;
        `PGM_OFS_CLK_ROUTE:
          clkRoute_ff <= wb_dat_i[7:0] & `PGM_MASK_CLK_ROUTE;
        default: ;
      endcase
    end
  end

  genvar i;

  // port G: lower half is owned elsewhere and passes through
  generate
    for (i = 0; i < 8; i++) begin : g_port_g
      if (i < 4) begin : g_low
        assign nxt_padG.out[i] = gpioG.out[i];
        assign nxt_padG.oe[i]  = gpioG.oe[i];
      end else begin : g_high
        logic com;
        assign com = (gUpperSel_ff[2*(i-4) +: 2] ==
                      `PGM_CODE_ALT3);
        assign nxt_padG.out[i] = com ? lcdComDrv[i-4] : gpioG.out[i];
        assign nxt_padG.oe[i]  = com ? 1'b1 : gpioG.oe[i];
      end
    end
  endgenerate

  // port J: low pins carry commons, all pins carry segments
  generate
    for (i = 0; i < 8; i++) begin : g_port_j
      logic [1:0] code;
      logic       seg;
      logic       com;
      if (i < 4) begin : g_low
        assign code = jLowerSel_ff[2*i +: 2];
        assign com  = (code == `PGM_CODE_ALT2);
      end else begin : g_high
        assign code = jUpperSel_ff[2*(i-4) +: 2];
        assign com  = 1'b0;
        // shared clock pin only while the pin is not a segment
        assign nxt_ptClkFromJ[i] = (code != `PGM_CODE_ALT3) ?
                                   padJIn[i] : 1'b0;
      end
      assign seg = (code == `PGM_CODE_ALT3);
      assign nxt_padJ.out[i] = seg ? lcdSegDrv[(i < 4) ? i : i + 4] :
                               com ? lcdComDrv[i + 4] : gpioJ.out[i];
      assign nxt_padJ.oe[i]  = (seg | com) ? 1'b1 : gpioJ.oe[i];
    end
  endgenerate

  // port H: timer pins at 0,1,6,7, clock/analog pins at 2..5
  generate
    for (i = 0; i < 8; i++) begin : g_port_h
      logic [1:0] code;
      logic       seg;
      logic       alt;
      logic       base;
      assign code = hSel[2*i +: 2];
      assign seg  = (code == `PGM_CODE_ALT3);
      assign alt  = (code == `PGM_CODE_ALT2);
      assign base = ~seg & ~alt;
      if (H_TIMER[i]) begin : g_tmr
        localparam int TMR = (i < 2) ? i + 4 : i;
        // capture sees the pin only in the I/O code
        assign nxt_timerIn.ptCap[TMR] =
          base ? padHIn[i] : 1'b0;
        assign nxt_padH.out[i] = seg ? lcdSegDrv[H_SEG[6*i +: 6]] :
                                 alt ? ptOut[TMR] : gpioH.out[i];
        assign nxt_padH.oe[i]  = (seg | alt) ? 1'b1 : gpioH.oe[i];
      end else begin : g_clk
        localparam int CK = i + 2;
        // analog pins float the digital driver
        assign nxt_analogSel[i + 10] = alt;
        assign nxt_timerIn.ptClk[CK] =
          base ? padHIn[i] : 1'b0;
        assign nxt_padH.out[i] = seg ? lcdSegDrv[H_SEG[6*i +: 6]] :
                                 alt ? 1'b0 : gpioH.out[i];
        assign nxt_padH.oe[i]  = seg ? 1'b1 :
                                 alt ? 1'b0 : gpioH.oe[i];
      end
    end
  endgenerate

  // routed clocks: a plain 2:1 mux keeps the other pin out
  generate
    for (i = 0; i < 4; i++) begin : g_pt_route
      assign nxt_timerIn.ptClk[i] =
        clkRoute_ff[`PGM_PT_ROUTE_LSB + i] ?
        ptClkPinB[i] : ptClkPinA[i];
    end
    for (i = 0; i < 3; i++) begin : g_st_route
      assign nxt_timerIn.stClk[i] =
        clkRoute_ff[`PGM_ST_ROUTE_LSB + i] ?
        stClkPinB[i] : stClkPinA[i];
    end
  endgenerate

  // registered outputs: one cycle latency, no glitches on pads
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      padG       <= '0;
      padH       <= '0;
      padJ       <= '0;
      analogSel  <= '0;
      ptClkFromJ <= '0;
      timerIn    <= '0;
    end else begin
      padG       <= nxt_padG;
      padH       <= nxt_padH;
      padJ       <= nxt_padJ;
      analogSel  <= nxt_analogSel;
      ptClkFromJ <= nxt_ptClkFromJ;
      timerIn    <= nxt_timerIn;
    end
  end
endmodule : pgm_port_ghj_mux

// *** bench/pgm_port_ghj_mux_sva.sv ***
`timescale 1ns/1ps
module pgm_port_ghj_mux_sva (
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [7:0]            wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire pgm_pkg::pgm_pad_bus_t gpioG,
  input wire logic [7:0]            lcdComDrv,
  input wire pgm_pkg::pgm_pad_bus_t padG,
  input wire logic [3:0]            ptClkPinA,
  input wire logic [3:0]            ptClkPinB,
  input wire logic [2:0]            stClkPinA,
  input wire logic [2:0]            stClkPinB,
  input wire pgm_pkg::pgm_timer_in_t timerIn
);
  import pgm_pkg::*;
  logic [7:0] gSh_ff;
  logic [7:0] rtSh_ff;
  logic       wrReq;
  // shadow selects, taken on the same edge as the slave
  assign wrReq = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gSh_ff  <= 8'h00;
      rtSh_ff <= 8'h00;
    end else if (wrReq) begin
      if (wb_adr_i == 8'h00) gSh_ff <= wb_dat_i[7:0];
      if (wb_adr_i == 8'h14) rtSh_ff <= wb_dat_i[7:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_rd_hi_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read upper bits set");
  // outputs lag one cycle; skip the edge right after reset
  a_pt_route: assert property (!$past(sys_rst) |-> timerIn.ptClk[3:0] ==
    $past((rtSh_ff[6:3] & ptClkPinB) | (~rtSh_ff[6:3] & ptClkPinA)))
    else $error("timer clock route wrong");
  a_st_route: assert property (!$past(sys_rst) |-> timerIn.stClk ==
    $past((rtSh_ff[2:0] & stClkPinB) | (~rtSh_ff[2:0] & stClkPinA)))
    else $error("std clock route wrong");
  a_rt_b7_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == 8'h14 |-> !wb_dat_o[7]) else $error("route bit7 set");
  a_g_com: assert property (!$past(sys_rst) && $past(gSh_ff[7:6]) == 2'h3
    |-> padG.out[7] == $past(lcdComDrv[3]) && padG.oe[7])
    else $error("G7 not common 3");
  a_g_io: assert property (!$past(sys_rst) && $past(gSh_ff[1:0]) != 2'h3
    |-> padG.out[4] == $past(gpioG.out[4])) else $error("G4 not I/O");
endmodule : pgm_port_ghj_mux_sva
bind pgm_port_ghj_mux pgm_port_ghj_mux_sva chk_i (.*);

// *** bench/pgm_pin_model.sv ***
`timescale 1ns/1ps
module pgm_pin_model (
  output logic [7:0]  padGIn,
  output logic [7:0]  padHIn,
  output logic [7:0]  padJIn,
  output logic [7:4]  ptOut,
  output logic [7:0]  lcdComDrv,
  output logic [42:0] lcdSegDrv,
  output logic [3:0]  ptClkPinA,
  output logic [3:0]  ptClkPinB,
  output logic [2:0]  stClkPinA,
  output logic [2:0]  stClkPinB
);
  // mixed levels so a swapped or stuck pin shows up
  assign padGIn    = 8'h96;
  assign padHIn    = 8'h65;
  assign padJIn    = 8'h3C;
  assign ptOut     = 4'h9;
  assign lcdComDrv = 8'hC6;
  assign lcdSegDrv = 43'h7A5C3A596E9;
  // candidates are complements: a wrong route always differs
  assign ptClkPinA = 4'h6;
  assign ptClkPinB = 4'h9;
  assign stClkPinA = 3'h5;
  assign stClkPinB = 3'h2;
endmodule : pgm_pin_model

// *** bench/pgm_port_ghj_mux_tb.sv ***
`timescale 1ns/1ps
module pgm_port_ghj_mux_tb;
  import pgm_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, padGIn, padHIn, padJIn, lcdComDrv, rd;
  logic [3:0] wb_sel_i, ptClkPinA, ptClkPinB;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:4] ptOut, ptClkFromJ;
  logic [42:0] lcdSegDrv;
  logic [2:0] stClkPinA, stClkPinB;
  logic [31:0] smDat;
  pgm_pad_bus_t smPadJ;
  logic [15:12] analogSel;
  pgm_pad_bus_t gpioG, gpioH, gpioJ, padG, padH, padJ;
  pgm_timer_in_t timerIn;
  logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  int n_fail = 0;
  int tests_run = 0;
  int cycCnt = 0;

  pgm_pin_model pins (.*);
  pgm_port_ghj_mux dut (.*);
  // smallest part: J upper bits 3:0 are not implemented
  pgm_port_ghj_mux #(
    .PART_SIZE(PGM_SIZE_SMALL)
  ) dutSmall (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .wb_cyc_i   (wb_cyc_i),
    .wb_stb_i   (wb_stb_i),
    .wb_we_i    (wb_we_i),
    .wb_adr_i   (wb_adr_i),
    .wb_sel_i   (wb_sel_i),
    .wb_dat_i   (wb_dat_i),
    .wb_dat_o   (smDat),
    .wb_ack_o   (),
    .gpioG      (gpioG),
    .gpioH      (gpioH),
    .gpioJ      (gpioJ),
    .padGIn     (padGIn),
    .padHIn     (padHIn),
    .padJIn     (padJIn),
    .ptOut      (ptOut),
    .lcdComDrv  (lcdComDrv),
    .lcdSegDrv  (lcdSegDrv),
    .ptClkPinA  (ptClkPinA),
    .ptClkPinB  (ptClkPinB),
    .stClkPinA  (stClkPinA),
    .stClkPinB  (stClkPinB),
    .padG       (),
    .padH       (),
    .padJ       (smPadJ),
    .analogSel  (),
    .ptClkFromJ (),
    .timerIn    ()
  );

  always #10 core_clk = ~core_clk;

  // hang guard, far above the fewer than one hundred cycles used
  always @(posedge core_clk) begin
    cycCnt <= cycCnt + 1;
    if (cycCnt == 5000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end

  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    // without an ack, only the bench's cycle ceiling ends this wait
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic chk(input logic [63:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // outputs are one register stage behind the select
  task settle;
    repeat (2) @(negedge core_clk);
  endtask : settle

  task final_report;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    sys_rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    gpioG = {8'h5A, 8'h0F};
    gpioH = {8'hA5, 8'hF0};
    gpioJ = {8'h5A, 8'h33};
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (ofs[i]) begin
      wb(1'b0, ofs[i], 8'h00);
      chk(rd, 8'h00);
    end
    wb(1'b1, 8'h00, 8'hFF);
    wb(1'b1, 8'h04, 8'hE4);
    wb(1'b1, 8'h0C, 8'hE4);
    wb(1'b1, 8'h10, 8'hFF);
    wb(1'b1, 8'h14, 8'hFF);
    wb(1'b0, 8'h14, 8'h00);
    chk(rd, 8'h7F);
    wb(1'b0, 8'h10, 8'h00);
    chk(rd, 8'hFF);
    chk(smDat, 32'h0000_00F0);
    settle;
    chk(smPadJ.out[5:4], gpioJ.out[5:4]);
    chk({padG.out[7:4], padG.oe[7:4]}, {lcdComDrv[3:0], 4'hF});
    chk(padG.out[3:0], gpioG.out[3:0]);
    chk({padH.out[3], timerIn.ptClk[5:4]}, {lcdSegDrv[41], 2'b00});
    chk(analogSel[12], 1'b1);
    chk(timerIn.ptCap[5:4], padHIn[1:0]);
    chk(timerIn.ptClk[7:6], padHIn[5:4]);
    chk(padJ.out[7:3], {lcdSegDrv[11:8], lcdSegDrv[3]});
    chk({padJ.out[2:0]}, {lcdComDrv[6], gpioJ.out[1:0]});
    chk(ptClkFromJ, 4'h0);
    chk({timerIn.ptClk[3:0], timerIn.stClk}, {ptClkPinB, stClkPinB});
    wb(1'b1, 8'h08, 8'h9C);
    settle;
    chk({padH.out[7], padH.oe[7], timerIn.ptCap[7]}, {ptOut[7], 2'b10});
    chk(timerIn.ptCap[6], padHIn[6]);
    chk({padH.out[5], timerIn.ptClk[6]}, {lcdSegDrv[39], padHIn[4]});
    wb(1'b1, 8'h14, 8'h00);
    settle;
    chk({timerIn.ptClk[3:0], timerIn.stClk}, {ptClkPinA, stClkPinA});
    final_report;
  end
endmodule : pgm_port_ghj_mux_tb
